// ==== design/eioda_mv_to_code.sv ====
`timescale 1ns/1ps
module eioda_mv_to_code
   import eioda_pkg::*;
(
   // programmed level
   input  wire logic signed [31:0]      level_mv,
   // converter code
   output logic             [DAC_W-1:0] code
);

   logic signed [31:0] clamped;
   logic signed [31:0] steps;

   always_comb begin
      clamped = level_mv;
      if (level_mv > MV_LIMIT) begin
         clamped = MV_LIMIT;
      end else if (level_mv < -MV_LIMIT) begin
         clamped = -MV_LIMIT;
      end
      // signed divide truncates toward zero, so values between 5 mV steps fall to the step nearer zero
      steps = clamped / MV_STEP;
      code  = DAC_W'(steps + CODE_MID);
   end

endmodule

// ==== design/eioda_pkg.sv ====
package eioda_pkg;

   // ---------------------------------------------------------------
   // register indices; byte address is four times the index
   // ---------------------------------------------------------------
   localparam int          ADDR_W          = 18;
   localparam logic [15:0] IDX_DIRECTION   = 16'hb7fc;
   localparam logic [15:0] IDX_DIGITAL     = 16'hb806;
   localparam logic [15:0] IDX_LEVEL0      = 16'hb810;
   localparam logic [15:0] IDX_LEVEL1      = 16'hb811;
   localparam logic [15:0] IDX_LEVEL2      = 16'hb812;
   localparam logic [15:0] IDX_LEVEL3      = 16'hb813;
   localparam logic [15:0] IDX_UPDATE      = 16'hb81a;

   // ---------------------------------------------------------------
   // field layout and reset values
   // ---------------------------------------------------------------
   localparam int          MAX_GROUPS      = 3;
   localparam int          GROUP_W         = 8;
   localparam int          MAX_LINES       = MAX_GROUPS * GROUP_W;
   localparam int          NUM_LEVELS      = 4;
   localparam int          DAC_W           = 12;
   localparam int          UPDATE_BIT      = 0;
   localparam logic [2:0]  DIR_RESET       = 3'h0;
   localparam logic [23:0] DOUT_RESET      = 24'h000000;
   localparam logic [31:0] LEVEL_RESET     = 32'h00000000;

   // ---------------------------------------------------------------
   // analog scaling, millivolts
   // ---------------------------------------------------------------
   localparam int signed   MV_LIMIT        = 10000;
   localparam int signed   MV_STEP         = 5;
   localparam int signed   CODE_MID        = MV_LIMIT / MV_STEP;
   localparam logic [11:0] DAC_RESET       = 12'(CODE_MID);

   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic              read;
      logic              write;
      logic [ADDR_W-1:0] address;
      logic [31:0]       writedata;
      logic [3:0]        byteenable;
   } eioda_amm_req_t;

   typedef struct packed {
      logic [MAX_LINES-1:0] data;
      logic [MAX_LINES-1:0] oe;
   } eioda_pin_out_t;

   typedef struct packed {
      logic [NUM_LEVELS-1:0][DAC_W-1:0] code;
      logic                             load;
   } eioda_dac_out_t;

   typedef struct packed {
      logic                             ack;
      logic [31:0]                      rdata;
      logic [MAX_GROUPS-1:0]            dir;
      logic [MAX_LINES-1:0]             dout;
      logic [MAX_LINES-1:0]             pin_smp;
      logic [NUM_LEVELS-1:0][31:0]      level;
      logic [NUM_LEVELS-1:0][DAC_W-1:0] dac;
      logic                             dac_load;
   } eioda_state_t;

endpackage

// ==== design/eioda_top.sv ====
// Behaviour
// - bracket variant: 24 lines, per-byte direction
// - connector variant: 16 lines, two groups
// - direction bits 0,1,2 select output groups
// - cleared direction bit makes group inputs
// - data read returns sampled pin states
// - data write updates output groups only
// - line n sits at data bit n
// - writes to bits 31..24 ignored
// - levels signed millivolts, +-10000, 5 mV
// - level converted to 12-bit converter code
// - level read returns programmed register value
// - converters load together on update write with bit 0 set
`timescale 1ns/1ps
module eioda_top
   import eioda_pkg::*;
#(
   parameter int NUM_GROUPS = 3
)
(
   // clock and reset
   input  wire logic                 clk_sys,
   input  wire logic                 rst_b,
   // avalon-mm slave
   input  wire eioda_amm_req_t       avs_req,
   output logic [31:0]               avs_readdata,
   output logic                      avs_waitrequest,
   // digital lines
   input  wire logic [MAX_LINES-1:0] pin_in,
   output eioda_pin_out_t            pin_drv,
   // analog converters
   output eioda_dac_out_t            dac
);

   // ---------------------------------------------------------------
   // variant masks
   // ---------------------------------------------------------------
   localparam logic [MAX_GROUPS-1:0] GRP_MASK =
      MAX_GROUPS'((1 << NUM_GROUPS) - 1);

   function automatic logic [MAX_LINES-1:0] line_mask();
      logic [MAX_LINES-1:0] m;
      m = '0;
      for (int g = 0; g < MAX_GROUPS; g++) begin
         m[g*GROUP_W +: GROUP_W] = {GROUP_W{GRP_MASK[g]}};
      end
      return m;
   endfunction

   localparam logic [MAX_LINES-1:0] LINE_MASK = line_mask();

   function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  be);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   eioda_state_t                     st_r;
   eioda_state_t                     st_nxt;
   logic [NUM_LEVELS-1:0][DAC_W-1:0] conv_code;
   logic [15:0]                      word_idx;
   logic                             req;
   logic                             wr_fire;

   assign word_idx = avs_req.address[ADDR_W-1:2];
   assign req      = avs_req.read | avs_req.write;
   // every access waits exactly one cycle so read data come from a flop
   assign avs_waitrequest = req & ~st_r.ack;
   assign wr_fire         = avs_req.write & st_r.ack;

   // ---------------------------------------------------------------
   // level converters
   // ---------------------------------------------------------------
   for (genvar i = 0; i < NUM_LEVELS; i++) begin : g_conv
      eioda_mv_to_code u_conv (
         .level_mv (signed'(st_r.level[i])),
         .code     (conv_code[i])
      );
   end

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      st_nxt          = st_r;
      st_nxt.dac_load = 1'b0;
      st_nxt.ack      = req & ~st_r.ack;
      // lines are free-running; sampled each cycle regardless of direction
      st_nxt.pin_smp  = pin_in & LINE_MASK;

      // read data latched in the wait cycle; unmapped reads give zero
      if (avs_req.read & ~st_r.ack) begin
         case (word_idx)
            IDX_DIRECTION: st_nxt.rdata = 32'(st_r.dir);
            IDX_DIGITAL:   st_nxt.rdata = 32'(st_r.pin_smp);
            IDX_LEVEL0:    st_nxt.rdata = st_r.level[0];
            IDX_LEVEL1:    st_nxt.rdata = st_r.level[1];
            IDX_LEVEL2:    st_nxt.rdata = st_r.level[2];
            IDX_LEVEL3:    st_nxt.rdata = st_r.level[3];
            default:       st_nxt.rdata = 32'h00000000;
         endcase
      end

      if (wr_fire) begin
         case (word_idx)
            IDX_DIRECTION: begin
               if (avs_req.byteenable[0]) begin
                  // absent groups stay inputs in the smaller variant
                  st_nxt.dir = avs_req.writedata[MAX_GROUPS-1:0]
                             & GRP_MASK;
               end
            end
            IDX_DIGITAL: begin
               // byte 3 has no lines and is simply never looked at
               for (int g = 0; g < MAX_GROUPS; g++) begin
                  if (st_r.dir[g] && avs_req.byteenable[g]) begin
                     st_nxt.dout[g*GROUP_W +: GROUP_W] =
                        avs_req.writedata[g*GROUP_W +: GROUP_W];
                  end
               end
            end
            IDX_LEVEL0, IDX_LEVEL1, IDX_LEVEL2, IDX_LEVEL3: begin
               // stored raw; converted codes reach dac.code only on update
               st_nxt.level[word_idx[1:0]] =
                  merge_bytes(st_r.level[word_idx[1:0]],
                              avs_req.writedata,
                              avs_req.byteenable);
            end
            IDX_UPDATE: begin
               if (avs_req.byteenable[0] && avs_req.writedata[UPDATE_BIT]) begin
                  st_nxt.dac      = conv_code;
                  st_nxt.dac_load = 1'b1;
               end
            end
            default: begin
               st_nxt.dac_load = 1'b0;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         st_r.ack      <= 1'b0;
         st_r.rdata    <= 32'h00000000;
         st_r.dir      <= DIR_RESET;
         st_r.dout     <= DOUT_RESET;
         st_r.pin_smp  <= '0;
         st_r.level    <= {NUM_LEVELS{LEVEL_RESET}};
         st_r.dac      <= {NUM_LEVELS{DAC_RESET}};
         st_r.dac_load <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   always_comb begin
      pin_drv.data = st_r.dout & LINE_MASK;
      for (int g = 0; g < MAX_GROUPS; g++) begin
         pin_drv.oe[g*GROUP_W +: GROUP_W] = {GROUP_W{st_r.dir[g]}};
      end
   end

   assign avs_readdata = st_r.rdata;
   assign dac.code     = st_r.dac;
   assign dac.load     = st_r.dac_load;

endmodule

// ==== testbench/eioda_far_model.sv ====
`timescale 1ns/1ps
module eioda_far_model
   import eioda_pkg::*;
(
   // device side
   input  wire eioda_pin_out_t       pin_drv,
   // instrument side
   input  wire logic [MAX_LINES-1:0] ext_lvl,
   output logic      [MAX_LINES-1:0] pin_in
);
   // driven lines loop back, the rest follow the instrument
   assign pin_in = (pin_drv.oe & pin_drv.data) | (~pin_drv.oe & ext_lvl);
endmodule

// ==== testbench/eioda_top_props.sv ====
`timescale 1ns/1ps
module eioda_top_props
   import eioda_pkg::*;
#(
   parameter int NUM_GROUPS = 3
)
(
   // clock and reset
   input wire logic                 clk_sys,
   input wire logic                 rst_b,
   // register bus
   input wire eioda_amm_req_t       avs_req,
   input wire logic [31:0]          avs_readdata,
   input wire logic                 avs_waitrequest,
   // lines and converters
   input wire logic [MAX_LINES-1:0] pin_in,
   input wire eioda_pin_out_t       pin_drv,
   input wire eioda_dac_out_t       dac
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   wire        wr  = avs_req.write & ~avs_waitrequest;
   wire [15:0] idx = avs_req.address[17:2];
   AST_RD_WAIT: assert property (avs_req.read && avs_waitrequest |=> !avs_waitrequest)
      else $error("read not answered after one wait cycle");
   AST_OE_CHG: assert property ($changed(pin_drv.oe) |-> $past(wr && idx == IDX_DIRECTION))
      else $error("line enables moved without a direction write");
   AST_OE_BYTE: assert property (pin_drv.oe[7:0] inside {8'h00, 8'hff} &&
      pin_drv.oe[15:8] inside {8'h00, 8'hff} && pin_drv.oe[23:16] inside {8'h00, 8'hff})
      else $error("line enables split inside a group");
   AST_VARIANT: assert property (NUM_GROUPS < 3 |-> pin_drv.oe[23:16] == 8'h00)
      else $error("absent group driven");
   AST_DOUT: assert property (wr && idx == IDX_DIGITAL && avs_req.byteenable[0] &&
      pin_drv.oe[0] |=> pin_drv.data[7:0] == $past(avs_req.writedata[7:0]))
      else $error("output group did not take written byte");
   AST_DAC_HOLD: assert property ($changed(dac.code) |-> dac.load)
      else $error("converter code moved without load");
   AST_DAC_LOAD: assert property (wr && idx == IDX_UPDATE && avs_req.byteenable[0] &&
      avs_req.writedata[0] |=> dac.load ##1 !dac.load)
      else $error("update write gave no single load pulse");
   AST_CODE_MAX: assert property (dac.code[0] <= 12'hfa0 && dac.code[1] <= 12'hfa0 &&
      dac.code[2] <= 12'hfa0 && dac.code[3] <= 12'hfa0)
      else $error("converter code beyond full scale");
endmodule

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
module tb
   import eioda_pkg::*;
;
   logic                 clk_sys, rst_b, wreq;
   eioda_amm_req_t       req;
   logic [31:0]          rdata, rd, wd, seed;
   logic [3:0]           be;
   logic [MAX_LINES-1:0] pin_in, ext_lvl, dout_m, em;
   eioda_pin_out_t       pin_drv;
   eioda_dac_out_t       dac;
   int                   fail_count, checks, cyc, lv, code_m[4], lvl_m[4];
   int                   lv_tab[8] = '{-2000, 0, 3500, 10000, 10007, -20000, -7, 12};
   eioda_top #(.NUM_GROUPS(3)) i_eioda_top (.clk_sys(clk_sys), .rst_b(rst_b),
      .avs_req(req), .avs_readdata(rdata), .avs_waitrequest(wreq),
      .pin_in(pin_in), .pin_drv(pin_drv), .dac(dac));
   eioda_far_model i_eioda_far_model (.pin_drv(pin_drv), .ext_lvl(ext_lvl), .pin_in(pin_in));
   always #2 clk_sys = ~clk_sys;
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic int code_of(int v);
      if (v > 10000) v = 10000;
      if (v < -10000) v = -10000;
      return 2000 + v / 5;
   endfunction
   task automatic cmp(logic [31:0] got, logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // request held until the rising edge that sees waitrequest low; data taken there;
   // the next call or idle replaces the request, so nothing is assigned twice per step
   task automatic bus(bit w, logic [15:0] idx, logic [31:0] d, logic [3:0] b);
      req.read <= !w;
      req.write <= w;
      req.address <= {idx, 2'b00};
      req.writedata <= d;
      req.byteenable <= b;
      @(posedge clk_sys);
      while (wreq !== 1'b0) @(posedge clk_sys);
      rd = rdata;
   endtask
   task automatic idle(int n);
      req.read <= 1'b0;
      req.write <= 1'b0;
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic dac_chk();
      for (int i = 0; i < 4; i++) cmp(dac.code[i], code_m[i]);
   endtask
   task automatic wrap_up();
      $display("fail_count=%0d checks=%0d", fail_count, checks);
      if (fail_count == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         wrap_up();
      end
   end
   initial begin
      clk_sys = 0; rst_b = 0; req = '0; ext_lvl = '0; seed = 32'h00006730;
      fail_count = 0; checks = 0; cyc = 0; dout_m = '0; code_m = '{default: 2000};
      repeat (8) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(posedge clk_sys);
      bus(0, IDX_DIRECTION, 0, 4'hf);
      cmp(rd, 0);
      cmp(pin_drv.oe, 0);
      dac_chk();
      for (int c = 0; c < 8; c++) begin
         bus(1, IDX_DIRECTION, c, 4'h1);
         wd = xs();
         be = wd[3:0];
         wd = xs();
         bus(1, IDX_DIGITAL, wd, be);
         for (int g = 0; g < 3; g++) if (c[g] && be[g]) dout_m[g*8+:8] = wd[g*8+:8];
         wd = xs();
         ext_lvl <= wd[23:0];
         idle(3);
         for (int g = 0; g < 3; g++) em[g*8+:8] = c[g] ? dout_m[g*8+:8] : ext_lvl[g*8+:8];
         bus(0, IDX_DIRECTION, 0, 4'hf);
         cmp(rd, c);
         bus(0, IDX_DIGITAL, 0, 4'hf);
         cmp(rd, {8'h00, em});
      end
      for (int k = 0; k < 3; k++) begin
         for (int i = 0; i < 4; i++) begin
            lv = (k < 2) ? lv_tab[k*4+i] : $signed(xs()) % 12000;
            lvl_m[i] = lv;
            bus(1, 16'(IDX_LEVEL0 + i), lv, 4'hf);
         end
         dac_chk();
         for (int i = 0; i < 4; i++) begin
            bus(0, 16'(IDX_LEVEL0 + i), 0, 4'hf);
            cmp(rd, lvl_m[i]);
         end
         bus(1, IDX_UPDATE, 32'h2, 4'hf);
         idle(2);
         dac_chk();
         bus(1, IDX_UPDATE, 32'h1, 4'hf);
         for (int i = 0; i < 4; i++) code_m[i] = code_of(lvl_m[i]);
         idle(2);
         dac_chk();
      end
      bus(0, 16'h0001, 0, 4'hf);
      cmp(rd, 0);
      idle(1);
      wrap_up();
   end
endmodule
bind eioda_top eioda_top_props #(.NUM_GROUPS(NUM_GROUPS)) i_eioda_top_props (
   .clk_sys(clk_sys), .rst_b(rst_b), .avs_req(avs_req), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .pin_in(pin_in), .pin_drv(pin_drv), .dac(dac));
